// >>> rtl/tcs_cfg.svh
// register map, field positions and timing constants of the channel select block
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH
`define TCS_ADDR_W 8
`define TCS_OFF_CTRL 8'h00
`define TCS_OFF_MCR 8'h04
`define TCS_OFF_FRAME 8'h08
`define TCS_OFF_TXDATA 8'h0C
`define TCS_OFF_RXDATA 8'h10
`define TCS_OFF_STAT 8'h14
`define TCS_OFF_RXEN0 8'h20
`define TCS_OFF_TXEN0 8'h30
`define TCS_CTRL_TXEN 0
`define TCS_CTRL_RXEN 1
`define TCS_CTRL_DLYEN 2
`define TCS_CTRL_TXIM 5:4
`define TCS_CTRL_RXIM 7:6
`define TCS_MCR_RXMC 0
`define TCS_MCR_TXPOL 2:1
`define TCS_MCR_RXENH 3
`define TCS_MCR_TXENH 4
`define TCS_MCR_RPA 6:5
`define TCS_MCR_RPB 8:7
`define TCS_MCR_XPA 10:9
`define TCS_MCR_XPB 12:11
`define TCS_MCR_RCB 15:13
`define TCS_MCR_XCB 18:16
`define TCS_FRM_TXLEN 6:0
`define TCS_FRM_RXLEN 14:8
`define TCS_FRM_WLEN 20:16
`define TCS_WLEN_RST 5'h07
`define TCS_IRQ_PER_COPY 2'h0
`define TCS_TURN_ON_DELAY_NS 20
`define TCS_CLK_NS 10
`define TCS_TURN_ON_CYC ((`TCS_TURN_ON_DELAY_NS + `TCS_CLK_NS - 1) / `TCS_CLK_NS)
`endif

// >>> rtl/tcs_oe_delay.sv
// data-out enable with optional extra turn-on delay
`timescale 1ns/1ns
`default_nettype none
`include "tcs_cfg.svh"
module tcs_oe_delay #(
    parameter int unsigned DELAY_CYC = `TCS_TURN_ON_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    tcs_oe_if.dly oe
);
    localparam int unsigned CW = $clog2(DELAY_CYC + 1);
    logic [CW-1:0] cnt_r;
    wire logic wait_more = oe.delay_en && (cnt_r != CW'(DELAY_CYC));

    generate
        if (DELAY_CYC < 1) begin : g_chk
            $error("turn-on delay must be at least one cycle");
        end
    endgenerate

    // only the enable is held back; data timing is untouched
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oe.oe_n <= 1'b1;
            cnt_r <= '0;
        end else if (!oe.drive_req) begin
            oe.oe_n <= 1'b1;
            cnt_r <= '0;
        end else if (oe.oe_n && wait_more) begin
            cnt_r <= cnt_r + CW'(1);
        end else begin
            oe.oe_n <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/tcs_oe_if.sv
// carrier between frame logic and the data-out enable delay
`timescale 1ns/1ns
`default_nettype none
interface tcs_oe_if;
    logic drive_req;
    logic delay_en;
    logic oe_n;
    modport ctl (output drive_req, output delay_en, input oe_n);
    modport dly (input drive_req, input delay_en, output oe_n);
endinterface
`default_nettype wire

// >>> rtl/tcs_pkg.sv
// types shared by the channel select block
package tcs_pkg;
    typedef enum logic [1:0] {
        TCS_POL_ALL = 2'b00,
        TCS_POL_SEL = 2'b01,
        TCS_POL_MASK = 2'b10,
        TCS_POL_SYM = 2'b11
    } tcs_pol_t;
    typedef enum logic {
        TCS_IDLE = 1'b0,
        TCS_ACTIVE = 1'b1
    } tcs_frm_t;
endpackage

// >>> rtl/tcs_top.sv
// multichannel selection and data-out driver control of a tdm serial port
`timescale 1ns/1ns
`default_nettype none
`include "tcs_cfg.svh"
module tcs_top #(
    parameter int unsigned DELAY_CYC = `TCS_TURN_ON_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [`TCS_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic tx_bit_clock,
    input wire logic frame_sync,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe_n,
    output logic tx_irq,
    output logic rx_irq
);
    // control fields
    logic tx_on_r, rx_on_r, data_out_turn_on_delay_en;
    logic [1:0] tx_irq_mode, rx_irq_mode;
    logic rx_multichan_en, rx_enhanced_select_en, tx_enhanced_select_en;
    tcs_pkg::tcs_pol_t tx_multichan_policy;
    logic [1:0] rx_blk_a_r, rx_blk_b_r, tx_blk_a_r, tx_blk_b_r;
    logic [6:0] tx_frame_length, rx_frame_length;
    logic [4:0] wlen_r;
    logic [127:0] rx_chan_r, tx_chan_r;
    logic [31:0] tx_data_reg, rx_data_reg, rd_val;
    logic tx_full_r, rx_full_r, rx_ovr_r;
    // pin synchronisers; stage one feeds only stage two
    logic bclk_s1, bclk_s2, bclk_s3, fs_s1, fs_s2, din_s1, din_s2;
    // serial engine state
    tcs_pkg::tcs_frm_t frm_r;
    logic [4:0] bit_r;
    logic [6:0] elem_r;
    logic [31:0] tx_shift_reg, rx_buffer_reg;
    logic drive_r, drive_nxt;
    tcs_oe_if oeif ();
    // address decode
    wire logic w_ctrl = wr && (addr == `TCS_OFF_CTRL);
    wire logic w_mcr = wr && (addr == `TCS_OFF_MCR);
    wire logic w_frame = wr && (addr == `TCS_OFF_FRAME);
    wire logic w_txd = wr && (addr == `TCS_OFF_TXDATA);
    wire logic r_rxd = rd && (addr == `TCS_OFF_RXDATA);

    // enhanced only when both directions ask for it
    wire logic enh = rx_enhanced_select_en && tx_enhanced_select_en;
    wire logic tx_mc = (tx_multichan_policy != tcs_pkg::TCS_POL_ALL);
    wire logic sym = (tx_multichan_policy == tcs_pkg::TCS_POL_SYM);

    // channel hit: enhanced uses all 128 bits, normal only register 0
    function automatic logic chan_hit(input logic [127:0] vec, input logic [6:0] n,
                                      input logic [1:0] pa, input logic [1:0] pb,
                                      input logic e);
        logic blk_ok;
        blk_ok = n[4] ? (pb == n[6:5]) : (pa == n[6:5]);
        if (e) begin
            chan_hit = vec[n];
        end else begin
            chan_hit = blk_ok && vec[n[4:0]];
        end
    endfunction

    // frame sequencing; a frame closes on its last falling edge as the far clock may stop
    wire logic rise = bclk_s2 && !bclk_s3;
    wire logic fall = !bclk_s2 && bclk_s3;
    wire logic active = (frm_r == tcs_pkg::TCS_ACTIVE);
    wire logic last_bit = (bit_r == wlen_r);
    wire logic last_elem = (elem_r == tx_frame_length);
    wire logic frame_end = fall && active && last_bit && last_elem;
    wire logic start = rise && (fs_s2 || (active && last_bit && !last_elem));
    wire logic [6:0] start_idx = fs_s2 ? 7'h00 : elem_r + 7'h01;
    // symmetric mode uses the receive blocks for transmit too
    wire logic [1:0] tpa = sym ? rx_blk_a_r : tx_blk_a_r;
    wire logic [1:0] tpb = sym ? rx_blk_b_r : tx_blk_b_r;
    wire logic tx_hit = chan_hit(tx_chan_r, start_idx, tpa, tpb, enh);
    wire logic rx_hit_t = chan_hit(rx_chan_r, start_idx, rx_blk_a_r, rx_blk_b_r, enh);
    wire logic rx_hit = chan_hit(rx_chan_r, elem_r, rx_blk_a_r, rx_blk_b_r, enh);

    // transmit policy decode
    logic tx_load, tx_drive;
    always_comb begin
        case (tx_multichan_policy)
            tcs_pkg::TCS_POL_ALL: begin
                tx_load = 1'b1;
                tx_drive = 1'b1;
            end
            tcs_pkg::TCS_POL_SEL: begin
                tx_load = tx_hit;
                tx_drive = tx_hit;
            end
            tcs_pkg::TCS_POL_MASK: begin
                tx_load = 1'b1;
                tx_drive = tx_hit;
            end
            default: begin
                // loads on receive enables; drives only where the transmit enable also hits
                tx_load = rx_hit_t;
                tx_drive = rx_hit_t && tx_hit;
            end
        endcase
    end

    wire logic do_load = start && tx_on_r && tx_load;
    wire logic rx_sel = !rx_multichan_en || rx_hit;
    wire logic rx_copy = fall && active && last_bit && rx_on_r && rx_sel
                         && (elem_r <= rx_frame_length);
    wire logic [31:0] tx_just = tx_data_reg << (5'h1F - wlen_r);
    wire logic [31:0] rx_word = {rx_buffer_reg[30:0], din_s2};
    wire logic [31:0] wmask = 32'hFFFF_FFFF >> (5'h1F - wlen_r);

    // drive only inside frame and only for elements that are driven
    always_comb begin
        drive_nxt = drive_r;
        if (!tx_on_r || frame_end) begin
            drive_nxt = 1'b0;
        end else if (start) begin
            drive_nxt = tx_drive;
        end
    end

    assign oeif.drive_req = drive_nxt;
    assign oeif.delay_en = data_out_turn_on_delay_en;
    assign serial_data_out_oe_n = oeif.oe_n;

    tcs_oe_delay #(
        .DELAY_CYC(DELAY_CYC)
    ) u_oe (
        .clk(clk),
        .rstn(rstn),
        .oe(oeif)
    );

    // register read decode
    always_comb begin
        rd_val = 32'h0000_0000;
        if (addr == `TCS_OFF_CTRL) begin
            rd_val[`TCS_CTRL_TXEN] = tx_on_r;
            rd_val[`TCS_CTRL_RXEN] = rx_on_r;
            rd_val[`TCS_CTRL_DLYEN] = data_out_turn_on_delay_en;
            rd_val[`TCS_CTRL_TXIM] = tx_irq_mode;
            rd_val[`TCS_CTRL_RXIM] = rx_irq_mode;
        end else if (addr == `TCS_OFF_MCR) begin
            rd_val[`TCS_MCR_RXMC] = rx_multichan_en;
            rd_val[`TCS_MCR_TXPOL] = tx_multichan_policy;
            rd_val[`TCS_MCR_RXENH] = rx_enhanced_select_en;
            rd_val[`TCS_MCR_TXENH] = tx_enhanced_select_en;
            rd_val[`TCS_MCR_RPA] = rx_blk_a_r;
            rd_val[`TCS_MCR_RPB] = rx_blk_b_r;
            rd_val[`TCS_MCR_XPA] = tx_blk_a_r;
            rd_val[`TCS_MCR_XPB] = tx_blk_b_r;
            rd_val[`TCS_MCR_RCB] = elem_r[6:4];
            rd_val[`TCS_MCR_XCB] = elem_r[6:4];
        end else if (addr == `TCS_OFF_FRAME) begin
            rd_val[`TCS_FRM_TXLEN] = tx_frame_length;
            rd_val[`TCS_FRM_RXLEN] = rx_frame_length;
            rd_val[`TCS_FRM_WLEN] = wlen_r;
        end else if (addr == `TCS_OFF_TXDATA) begin
            rd_val = tx_data_reg;
        end else if (addr == `TCS_OFF_RXDATA) begin
            rd_val = rx_data_reg;
        end else if (addr == `TCS_OFF_STAT) begin
            rd_val = {28'h000_0000, active, rx_ovr_r, rx_full_r, tx_full_r};
        end else if (addr[7:6] == 2'h0 && addr[5] && addr[1:0] == 2'h0) begin
            // 0x20..0x3C: receive then transmit enable words
            rd_val = addr[4] ? tx_chan_r[{addr[3:2], 5'h00} +: 32]
                             : rx_chan_r[{addr[3:2], 5'h00} +: 32];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= rd ? rd_val : 32'h0000_0000;
        end
    end

    // enable words: one per register index and direction
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_en
            wire logic w_rx = wr && (addr == `TCS_OFF_RXEN0 + 8'(4 * k));
            wire logic w_tx = wr && (addr == `TCS_OFF_TXEN0 + 8'(4 * k));
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    rx_chan_r[32*k +: 32] <= 32'h0000_0000;
                    tx_chan_r[32*k +: 32] <= 32'h0000_0000;
                end else begin
                    if (w_rx) rx_chan_r[32*k +: 32] <= wdata;
                    if (w_tx) tx_chan_r[32*k +: 32] <= wdata;
                end
            end
        end
    endgenerate

    // control writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_on_r <= 1'b0;
            rx_on_r <= 1'b0;
            data_out_turn_on_delay_en <= 1'b0;
            tx_irq_mode <= 2'h0;
            rx_irq_mode <= 2'h0;
        end else if (w_ctrl) begin
            tx_on_r <= wdata[`TCS_CTRL_TXEN];
            rx_on_r <= wdata[`TCS_CTRL_RXEN];
            data_out_turn_on_delay_en <= wdata[`TCS_CTRL_DLYEN];
            tx_irq_mode <= wdata[`TCS_CTRL_TXIM];
            rx_irq_mode <= wdata[`TCS_CTRL_RXIM];
        end
    end

    // software orders enables, then enhanced bits, then modes; no interlock here
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_multichan_en <= 1'b0;
            tx_multichan_policy <= tcs_pkg::TCS_POL_ALL;
            rx_enhanced_select_en <= 1'b0;
            tx_enhanced_select_en <= 1'b0;
            rx_blk_a_r <= 2'h0;
            rx_blk_b_r <= 2'h0;
            tx_blk_a_r <= 2'h0;
            tx_blk_b_r <= 2'h0;
        end else if (w_mcr) begin
            rx_multichan_en <= wdata[`TCS_MCR_RXMC];
            tx_multichan_policy <= tcs_pkg::tcs_pol_t'(wdata[`TCS_MCR_TXPOL]);
            rx_enhanced_select_en <= wdata[`TCS_MCR_RXENH];
            tx_enhanced_select_en <= wdata[`TCS_MCR_TXENH];
            rx_blk_a_r <= wdata[`TCS_MCR_RPA];
            rx_blk_b_r <= wdata[`TCS_MCR_RPB];
            tx_blk_a_r <= wdata[`TCS_MCR_XPA];
            tx_blk_b_r <= wdata[`TCS_MCR_XPB];
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_frame_length <= 7'h00;
            rx_frame_length <= 7'h00;
            wlen_r <= `TCS_WLEN_RST;
        end else if (w_frame) begin
            tx_frame_length <= wdata[`TCS_FRM_TXLEN];
            rx_frame_length <= wdata[`TCS_FRM_RXLEN];
            wlen_r <= wdata[`TCS_FRM_WLEN];
        end
    end
    // transmit holding word; a write in the copy cycle keeps the flag set
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_data_reg <= 32'h0000_0000;
            tx_full_r <= 1'b0;
        end else if (w_txd) begin
            tx_data_reg <= wdata;
            tx_full_r <= 1'b1;
        end else if (do_load) begin
            tx_full_r <= 1'b0;
        end
    end
    // pin synchronisers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {bclk_s1, bclk_s2, bclk_s3} <= 3'h0;
            {fs_s1, fs_s2} <= 2'h0;
            {din_s1, din_s2} <= 2'h0;
        end else begin
            {bclk_s1, bclk_s2, bclk_s3} <= {tx_bit_clock, bclk_s1, bclk_s2};
            {fs_s1, fs_s2} <= {frame_sync, fs_s1};
            {din_s1, din_s2} <= {serial_data_in, din_s1};
        end
    end
    // frame and element counters, advanced on bit clock rising edges
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frm_r <= tcs_pkg::TCS_IDLE;
            bit_r <= 5'h00;
            elem_r <= 7'h00;
        end else if (start) begin
            frm_r <= tcs_pkg::TCS_ACTIVE;
            bit_r <= 5'h00;
            elem_r <= start_idx;
        end else if (frame_end) begin
            frm_r <= tcs_pkg::TCS_IDLE;
            bit_r <= 5'h00;
        end else if (rise && active) begin
            bit_r <= bit_r + 5'h01;
        end
    end

    // transmit shifter: data timing does not depend on the delay bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_shift_reg <= 32'h0000_0000;
            serial_data_out <= 1'b0;
            drive_r <= 1'b0;
            tx_irq <= 1'b0;
        end else begin
            drive_r <= drive_nxt;
            tx_irq <= do_load && (tx_irq_mode == `TCS_IRQ_PER_COPY);
            if (do_load) begin
                tx_shift_reg <= tx_just;
                serial_data_out <= tx_just[31];
            end else if (start) begin
                tx_shift_reg <= 32'h0000_0000;
                serial_data_out <= 1'b0;
            end else if (rise && active) begin
                tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
                serial_data_out <= tx_shift_reg[30];
            end
        end
    end

    // receive shifter, sampled on falling edges
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_buffer_reg <= 32'h0000_0000;
            rx_data_reg <= 32'h0000_0000;
            rx_full_r <= 1'b0;
            rx_ovr_r <= 1'b0;
            rx_irq <= 1'b0;
        end else begin
            rx_irq <= rx_copy && (rx_irq_mode == `TCS_IRQ_PER_COPY);
            if (fall && active) begin
                rx_buffer_reg <= last_bit ? 32'h0000_0000 : rx_word;
            end
            // a copy in the read cycle wins over the clear
            if (rx_copy) begin
                rx_data_reg <= rx_word & wmask;
                rx_full_r <= 1'b1;
            end else if (r_rxd) begin
                rx_full_r <= 1'b0;
            end
            if (rx_copy && rx_full_r && !r_rxd) begin
                rx_ovr_r <= 1'b1;
            end else if (w_ctrl) begin
                rx_ovr_r <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the channel select block
`timescale 1ns/1ns
`default_nettype none
`include "tcs_cfg.svh"
module tb_top;
    localparam int DLY = 1;
    logic clk;
    logic rstn;
    logic [`TCS_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic bclk;
    logic fsync;
    logic sdin;
    logic sdo;
    logic oe_n;
    logic tx_irq;
    logic rx_irq;
    logic start;
    logic busy;
    int seed = 32'h0000_e780;
    int num_errors = 0;
    int n_checks = 0;
    int ntx, nrx, drv, t_oe, t_irq, t_oe0, t_irq0;
    int nb;
    logic [3:0] txexp, sh;
    tcs_top #(.DELAY_CYC(DLY)) u_tcs_top (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .tx_bit_clock(bclk), .frame_sync(fsync),
        .serial_data_in(sdin), .serial_data_out(sdo),
        .serial_data_out_oe_n(oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq)
    );
    tcs_line_model u_tcs_line_model (
        .start(start), .tx_bit_clock(bclk), .frame_sync(fsync),
        .serial_data_in(sdin), .busy(busy)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // driven bits of each loaded element, msb first, against the word written before it
    always @(negedge bclk) begin
        if (oe_n === 1'b0) begin
            drv++;
            sh = {sh[2:0], sdo};
            nb++;
            if (nb == 4) check({28'h0, sh}, {28'h0, txexp});
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bus_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, exp);
    endtask
    function automatic int cnt(input logic [1:0] pol, input logic [127:0] rxm,
                               input logic [127:0] txm, input int kind);
        int n;
        n = 0;
        for (int c = 0; c < 128; c++) begin
            if (kind == 2) n += rxm[c];
            else if (kind == 1) n += !pol ? 1 : (pol == 2'b11 ? rxm[c] & txm[c] : txm[c]);
            else n += !pol[0] ? 1 : (pol[1] ? rxm[c] : txm[c]);
        end
        return n;
    endfunction
    task automatic run_cfg(input logic [1:0] pol, input logic enh, input logic dly);
        logic [127:0] rxm, txm;
        logic [31:0] multichan_control_reg, rexp, txq, txn;
        int ridx, age, quiet;
        logic tx_p, rx_p;
        rxm = {$random(seed), $random(seed), $random(seed), $random(seed)};
        txm = {$random(seed), $random(seed), $random(seed), $random(seed)};
        if (pol == 2'b11) txm = txm & rxm;
        for (int k = 0; k < 4; k++) begin
            bus_write(`TCS_OFF_RXEN0 + 8'(4 * k), rxm[32 * k +: 32]);
            bus_write(`TCS_OFF_TXEN0 + 8'(4 * k), txm[32 * k +: 32]);
            bus_read(`TCS_OFF_TXEN0 + 8'(4 * k), txm[32 * k +: 32]);
        end
        bus_write(`TCS_OFF_CTRL, {29'h0, dly, 2'b11});
        multichan_control_reg = enh ? {19'h0, 8'($random(seed)), 5'h18} : 32'h0000_0008;
        bus_write(`TCS_OFF_MCR, multichan_control_reg);
        bus_write(`TCS_OFF_MCR, multichan_control_reg | {29'h0, pol, 1'b1});
        if (!enh) begin
            // a lone enhanced bit keeps partitioned mode with blocks 0
            rxm = {96'h0, rxm[31:0]};
            txm = {96'h0, txm[31:0]};
        end
        txq = $random(seed);
        bus_write(`TCS_OFF_TXDATA, txq);
        drv = 0;
        ntx = 0;
        nrx = 0;
        t_oe = -1;
        t_irq = -1;
        ridx = 0;
        age = 0;
        quiet = 0;
        tx_p = 1'b0;
        rx_p = 1'b0;
        @(posedge clk);
        start <= 1'b1;
        for (int i = 0; i < 9000 && quiet < 20; i++) begin
            @(posedge clk);
            start <= 1'b0;
            wr <= tx_p;
            rd <= rx_p && !tx_p;
            addr <= tx_p ? `TCS_OFF_TXDATA : `TCS_OFF_RXDATA;
            txn = $random(seed);
            wdata <= txn;
            if (tx_p) txq = txn;
            if (rx_p && !tx_p) begin
                rx_p = 1'b0;
                age = 2;
            end
            tx_p = 1'b0;
            @(negedge clk);
            if (age == 1) check(rdata, rexp);
            if (age != 0) age--;
            if (tx_irq === 1'b1) begin
                txexp = txq[3:0];
                nb = 0;
                tx_p = 1'b1;
                ntx++;
                if (t_irq < 0) t_irq = i;
            end
            if (rx_irq === 1'b1) begin
                rx_p = 1'b1;
                nrx++;
                while (ridx < 127 && !rxm[ridx]) ridx++;
                rexp = {28'h0, 4'(ridx) ^ 4'ha};
                ridx++;
            end
            if (t_oe < 0 && oe_n === 1'b0) t_oe = i;
            quiet = (busy === 1'b0) ? quiet + 1 : 0;
        end
        check(ntx, cnt(pol, rxm, txm, 0));
        check(drv, 4 * cnt(pol, rxm, txm, 1));
        check(nrx, cnt(pol, rxm, txm, 2));
        check({31'h0, oe_n}, 32'h0000_0001);
        bus_read(`TCS_OFF_MCR, multichan_control_reg | {13'h0, 6'h3f, 10'h0, pol, 1'b1});
        if (!pol && !dly) begin
            t_oe0 = t_oe;
            t_irq0 = t_irq;
        end
        if (dly) begin
            check(t_oe, t_oe0 + DLY);
            check(t_irq, t_irq0);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        num_errors++;
        finish_test;
    end
    initial begin
        rstn = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        start = 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        bus_read(`TCS_OFF_FRAME, 32'h0007_0000);
        bus_write(8'h40, $random(seed));
        bus_read(8'h40, 32'h0000_0000);
        bus_write(`TCS_OFF_FRAME, 32'h0003_7f7f);
        for (int p = 0; p < 4; p++) run_cfg(2'(p), 1'b1, 1'b0);
        run_cfg(2'b00, 1'b1, 1'b1);
        run_cfg(2'b01, 1'b0, 1'b0);
        finish_test;
    end
endmodule
`default_nettype wire

// >>> verif/tcs_line_model.sv
// far end of the tdm line: bit clock, frame sync and receive data
`timescale 1ns/1ns
`default_nettype none
module tcs_line_model #(
    parameter int N_ELEM = 128,
    parameter int WBITS = 4
) (
    input wire logic start,
    output logic tx_bit_clock,
    output logic frame_sync,
    output logic serial_data_in,
    output logic busy
);
    logic [3:0] word;
    initial begin
        tx_bit_clock = 1'b0;
        frame_sync = 1'b0;
        serial_data_in = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge start);
            busy = 1'b1;
            #3;
            for (int e = 0; e < N_ELEM; e++) begin
                word = 4'(e) ^ 4'ha;
                for (int b = WBITS - 1; b >= 0; b--) begin
                    frame_sync = (e == 0) && (b == WBITS - 1);
                    serial_data_in = word[b];
                    tx_bit_clock = 1'b1;
                    #62 tx_bit_clock = 1'b0;
                    #63;
                end
            end
            // clock stands still; released data flips so stale values never match
            frame_sync = 1'b0;
            serial_data_in = ~serial_data_in;
            busy = 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> verif/tcs_top_properties.sv
// assertions on the channel select top ports
`timescale 1ns/1ns
`default_nettype none
`include "tcs_cfg.svh"
module tcs_checker #(
    parameter int unsigned DELAY_CYC = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [`TCS_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic tx_bit_clock,
    input wire logic frame_sync,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe_n,
    input wire logic tx_irq,
    input wire logic rx_irq
);
    logic bclk_r;
    logic dly_r;
    logic txon_r;
    logic frm_r;
    logic [1:0] pol_r;
    logic [7:0] age_r;
    logic [7:0] idle_r;
    wire rise = tx_bit_clock && !bclk_r;
    wire ctl_wr = wr && addr == `TCS_OFF_CTRL;
    wire mcr_wr = wr && addr == `TCS_OFF_MCR;
    wire [7:0] age_nxt = rise ? 8'h00 : age_r + {7'h00, age_r != 8'hff};
    wire [7:0] idle_nxt = (tx_bit_clock != bclk_r) ? 8'h00 : idle_r + {7'h00, idle_r != 8'hff};
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bclk_r <= 1'b0;
            age_r <= 8'hff;
            idle_r <= 8'h00;
            frm_r <= 1'b0;
            dly_r <= 1'b0;
            txon_r <= 1'b0;
            pol_r <= 2'b00;
        end else begin
            bclk_r <= tx_bit_clock;
            age_r <= age_nxt;
            idle_r <= idle_nxt;
            frm_r <= (rise && frame_sync) || (frm_r && idle_r < 8'h1e);
            dly_r <= ctl_wr ? wdata[`TCS_CTRL_DLYEN] : dly_r;
            txon_r <= ctl_wr ? wdata[`TCS_CTRL_TXEN] : txon_r;
            pol_r <= mcr_wr ? wdata[`TCS_MCR_TXPOL] : pol_r;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_fall;
        !tx_bit_clock && bclk_r;
    endsequence
    a_idle_undriven: assert property (idle_r > 8'h1e |-> serial_data_out_oe_n)
        else $error("data out driven on idle link");
    a_turn_on_late: assert property (dly_r && $fell(serial_data_out_oe_n) |-> age_r >= DELAY_CYC + 2)
        else $error("turn-on not delayed");
    a_data_timing: assert property ($changed(serial_data_out) && !serial_data_out_oe_n |-> age_r <= 8'h05)
        else $error("data moved away from bit clock");
    a_all_drive: assert property (s_fall ##0 (frm_r && txon_r && pol_r == 2'b00) |-> !serial_data_out_oe_n)
        else $error("element not driven");
    a_tx_copy_time: assert property (tx_irq |-> tx_bit_clock && frm_r)
        else $error("tx copy outside element start");
    a_rx_copy_time: assert property (rx_irq |-> !tx_bit_clock && frm_r)
        else $error("rx copy outside element end");
    a_tx_irq_pulse: assert property ($rose(tx_irq) |=> !tx_irq [*8])
        else $error("tx irq too long");
    a_rx_irq_pulse: assert property (rx_irq |=> !rx_irq [*8])
        else $error("rx irq too long");
endmodule
bind tcs_top tcs_checker #(.DELAY_CYC(DELAY_CYC)) u_tcs_checker (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tx_bit_clock(tx_bit_clock), .frame_sync(frame_sync),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_out_oe_n(serial_data_out_oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq)
);
`default_nettype wire
